/* common/timer_one_pkg.sv */
// Package of register offsets, field positions, reset values and codes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package timer_one_pkg;
    localparam logic [4:0] ADDR_COUNT = 5'h00;
    localparam logic [4:0] ADDR_PERIOD = 5'h04;
    localparam logic [4:0] ADDR_CONTROL = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h10;
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h14;
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_SYNC = 2;
    localparam int BIT_SRC = 1;
    localparam logic [15:0] CONTROL_MASK = 16'ha076;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_GATE_END = 1;
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;
endpackage : timer_one_pkg

/* common/tick_if.sv */
// Interface carrying the prescaler control and its output tick.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tick_if;
    logic clear;
    logic enable;
    logic [1:0] sel;
    logic src_pulse;
    logic tick;
    modport ctrl (output clear, output enable, output sel,
        output src_pulse, input tick);
    modport scaler (input clear, input enable, input sel,
        input src_pulse, output tick);
endinterface : tick_if

/* src/prescaler.sv */
// Prescaler dividing the selected input pulse by 1, 8, 64 or 256.
// Assumes src_pulse is a one-cycle pulse in the clk_i domain.
`timescale 1ns/100ps
module prescaler import timer_one_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    tick_if.scaler tk
);
    logic [7:0] cnt_q;
    logic [7:0] limit;

    always_comb begin
        unique case (tk.sel)
            2'b00: limit = PS_DIV1;
            2'b01: limit = PS_DIV8;
            2'b10: limit = PS_DIV64;
            2'b11: limit = PS_DIV256;
        endcase
    end

    // Clear acts only while enabled; a halted prescaler keeps its count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (tk.clear && tk.enable) begin
            cnt_q <= 8'h00;
        end else if (tk.enable && tk.src_pulse) begin
            cnt_q <= (cnt_q >= limit) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    assign tk.tick = tk.enable && tk.src_pulse && (cnt_q >= limit);
endmodule : prescaler

/* src/timer_one_counter.sv */
// Sixteen-bit timer/counter with period match and Wishbone registers.
// Assumes a classic Wishbone master on clk_i and asynchronous pin inputs.
//
// Notes on behaviour
// - Timer mode counts each instruction cycle up to period, then wraps.
// - Synchronous counter counts synchronised external rising edges, wraps.
// - Asynchronous counter counts every external rising edge, wraps.
// - Idle stops counting when idle-stop is one; resumes after Idle.
// - Asynchronous counting also halts in Idle when idle-stop is set.
// - Gated mode counts instruction cycles only while gate pin is high.
// - Input clock is instruction cycle or the external pin, by source.
// - Prescaler divides input by 1, 8, 64 or 256 per two-bit field.
// - Prescaler clears on count write, run-enable clear and reset.
// - A disabled timer cannot reset its halted prescaler.
// - Control writes leave the count; only count writes change it.
// - In Sleep, counts only if enabled, external, and asynchronous.
// - Running in Sleep, counts to period then resets to zero.
// - Count-period match requests interrupt when its enable is set.
// - Match sets a sticky flag held until software clears it.
// - Gated mode also interrupts on the gate falling edge.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module timer_one_counter import timer_one_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic instr_cycle_i,
    input wire logic ext_clock_gate_pin_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] count_value_q;
    logic [15:0] period_value_q;
    logic [15:0] timer_control_word_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_enable_q;
    logic [1:0] pin_sync_q;
    logic pin_prev_q;
    logic [1:0] idle_sync_q;
    logic [1:0] sleep_sync_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic irq_q;
    logic req;
    logic wr_lo;
    logic wr_hi;
    logic wr_count;
    logic wr_control;
    logic pin_rise;
    logic pin_fall;
    logic pin_level;
    logic timer_run_enable;
    logic clock_source_sel;
    logic ext_sync_sel;
    logic gate_accum_enable;
    logic idle_stop_sel;
    logic halted;
    logic idle_halt;
    logic sleep_halt;
    logic [31:0] rdata;
    logic match;
    logic [15:0] wdata;
    logic [1:0] irq_set;

    tick_if tk ();

    prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tk(tk)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decode. Each access is answered one cycle after it is seen.
    assign req = cyc_i && stb_i && !ack_q;
    assign wr_lo = req && we_i && sel_i[0];
    assign wr_hi = req && we_i && sel_i[1];
    assign wr_count = (wr_lo || wr_hi) && (adr_i == ADDR_COUNT);
    assign wr_control = (wr_lo || wr_hi) && (adr_i == ADDR_CONTROL);

    always_comb begin
        wdata = 16'h0000;
        wdata[7:0] = dat_i[7:0];
        wdata[15:8] = dat_i[15:8];
    end

    assign timer_run_enable = timer_control_word_q[BIT_RUN];
    assign idle_stop_sel = timer_control_word_q[BIT_IDLE_STOP];
    assign gate_accum_enable = timer_control_word_q[BIT_GATE];
    assign ext_sync_sel = timer_control_word_q[BIT_SYNC];
    assign clock_source_sel = timer_control_word_q[BIT_SRC];

    ////////////////////////////////////////////////////////////////////
    // Pin and processor state synchronisers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_q <= 2'b00;
            pin_prev_q <= 1'b0;
            idle_sync_q <= 2'b00;
            sleep_sync_q <= 2'b00;
        end else begin
            pin_sync_q <= {pin_sync_q[0], ext_clock_gate_pin_i};
            pin_prev_q <= pin_sync_q[1];
            idle_sync_q <= {idle_sync_q[0], cpu_idle_i};
            sleep_sync_q <= {sleep_sync_q[0], cpu_sleep_i};
        end
    end

    // The asynchronous path is modelled on the same clock; only the
    // Sleep qualification differs between the two counter modes.
    assign pin_level = pin_sync_q[1];
    assign pin_rise = pin_level && !pin_prev_q;
    assign pin_fall = !pin_level && pin_prev_q;

    ////////////////////////////////////////////////////////////////////
    // Stop conditions for Idle and Sleep.
    // Idle stops every mode alike when the idle-stop bit is set.
    assign idle_halt = idle_sync_q[1] && idle_stop_sel;

    // Sleep stops the core clock, so only the unsynchronised external
    // counter may keep running; every other mode must freeze.
    assign sleep_halt = sleep_sync_q[1]
        && !(clock_source_sel && !ext_sync_sel);

    always_comb begin
        halted = idle_halt || sleep_halt;
    end

    // Input pulse selection ahead of the prescaler.
    always_comb begin
        tk.enable = timer_run_enable && !halted;
        tk.sel = timer_control_word_q[BIT_PS_HI:BIT_PS_LO];
        tk.clear = wr_count || (wr_hi && (adr_i == ADDR_CONTROL)
            && !wdata[BIT_RUN]);
        if (clock_source_sel) begin
            tk.src_pulse = pin_rise;
        end else if (gate_accum_enable) begin
            tk.src_pulse = instr_cycle_i && pin_level;
        end else begin
            tk.src_pulse = instr_cycle_i;
        end
    end

    assign match = (count_value_q == period_value_q);

    ////////////////////////////////////////////////////////////////////
    // Count register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_value_q <= COUNT_RESET;
        end else if (wr_count) begin
            if (sel_i[0]) begin
                count_value_q[7:0] <= wdata[7:0];
            end
            if (sel_i[1]) begin
                count_value_q[15:8] <= wdata[15:8];
            end
        end else if (tk.tick) begin
            if (match) begin
                count_value_q <= 16'h0000;
            end else begin
                count_value_q <= count_value_q + 16'h0001;
            end
        end
    end

    // Period and control registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_value_q <= PERIOD_RESET;
        end else if (adr_i == ADDR_PERIOD) begin
            if (wr_lo) begin
                period_value_q[7:0] <= wdata[7:0];
            end
            if (wr_hi) begin
                period_value_q[15:8] <= wdata[15:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_word_q <= CONTROL_RESET;
        end else if (wr_control) begin
            if (sel_i[0]) begin
                timer_control_word_q[7:0] <= wdata[7:0] & CONTROL_MASK[7:0];
            end
            if (sel_i[1]) begin
                timer_control_word_q[15:8] <= wdata[15:8]
                    & CONTROL_MASK[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and output.
    always_comb begin
        irq_set = 2'b00;
        irq_set[IRQ_MATCH] = tk.tick && match;
        irq_set[IRQ_GATE_END] = timer_run_enable && !clock_source_sel
            && gate_accum_enable && pin_fall && !halted;
    end

    // One sticky bit per event. A set in the same cycle as a clear wins,
    // so an event that lands on the clear write is never lost.
    for (genvar b = 0; b < 2; b++) begin : g_status
        logic clr_bit;
        assign clr_bit = wr_lo && (adr_i == ADDR_IRQ_CLEAR) && dat_i[b];
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                irq_status_q[b] <= 1'b0;
            end else if (irq_set[b]) begin
                irq_status_q[b] <= 1'b1;
            end else if (clr_bit) begin
                irq_status_q[b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_q <= 2'b00;
        end else if (wr_lo && (adr_i == ADDR_IRQ_ENABLE)) begin
            irq_enable_q <= dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_enable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data and acknowledge.
    // The clear register and unmapped offsets read as zero.
    always_comb begin
        rdata = 32'h00000000;
        unique case (adr_i)
            ADDR_COUNT: rdata = {16'h0000, count_value_q};
            ADDR_PERIOD: rdata = {16'h0000, period_value_q};
            ADDR_CONTROL: rdata = {16'h0000, timer_control_word_q};
            ADDR_IRQ_STATUS: rdata = {30'h0, irq_status_q};
            ADDR_IRQ_ENABLE: rdata = {30'h0, irq_enable_q};
            default: rdata = 32'h00000000;
        endcase
    end

    // The answer is registered, so the master sees it one cycle after
    // the request is taken; read data stays until the next read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (req && !we_i) begin
            dat_q <= rdata;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign irq_o = irq_q;
endmodule : timer_one_counter

/* dv/instr_source_model.sv */
// Instruction-cycle source standing in for the processor clock divider.
// Assumes the bench raises go_i right after a rising edge.
`timescale 1ns/100ps
module instr_source_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    output logic instr_cycle_o
);
    logic [1:0] phase_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !go_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    // One pulse for every four clocks, so 4*k clocks give k pulses.
    assign instr_cycle_o = go_i && phase_q == 2'h3;
endmodule : instr_source_model

/* dv/timer_one_counter_sva.sv */
// Checker of the bus answer and interrupt output of the timer.
// Assumes it is bound to timer_one_counter and sees only its ports.
`timescale 1ns/100ps
module timer_one_counter_sva import timer_one_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence rd_s(logic [4:0] a);
        req_s ##1 (ack_o && !we_i && adr_i == a);
    endsequence
    chk_ack_answer: assert property (req_s |=> ack_o)
        else $error("ack missing");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_reset_out: assert property (
        $past(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0)
        else $error("outputs not reset");
    chk_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
        else $error("upper data not zero");
    chk_unmapped_zero: assert property (rd_s(5'h18) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_clear_zero: assert property (
        rd_s(ADDR_IRQ_CLEAR) |-> dat_o == 32'h0)
        else $error("clear read not zero");
    chk_control_mask: assert property (
        rd_s(ADDR_CONTROL) |-> (dat_o[15:0] & ~CONTROL_MASK) == 16'h0)
        else $error("unused control bits set");
    chk_irq_sticky: assert property (
        irq_o && !(cyc_i && stb_i && we_i) && !$past(cyc_i && stb_i && we_i)
        |=> irq_o)
        else $error("irq dropped without write");
endmodule : timer_one_counter_sva
////////////////////////////////////////////////////////////////////////
bind timer_one_counter timer_one_counter_sva u_sva (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

/* dv/timer_one_counter_test.sv */
// Self-checking bench of the timer through its Wishbone registers.
// Assumes the instruction source model and the bound checker.
`timescale 1ns/100ps
module timer_one_counter_test import timer_one_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, pin = 1'b0;
    logic idle = 1'b0, slp = 1'b0, ack_o, irq_o, instr;
    logic [4:0] adr = 5'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int dv[4] = '{1, 8, 64, 256};
    always #10 clk_i = ~clk_i;
    instr_source_model u_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .instr_cycle_o(instr));
    timer_one_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .instr_cycle_i(instr),
        .ext_clock_gate_pin_i(pin), .cpu_idle_i(idle),
        .cpu_sleep_i(slp), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        wb(1'b0, a, 16'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic pul(input int k);
        go <= 1'b1;
        repeat (4 * k) @(posedge clk_i);
        go <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pul
    task automatic edg(input int k);
        repeat (k) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask : edg
    task automatic t_reset();
        rd(ADDR_PERIOD, PERIOD_RESET);
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_COUNT, COUNT_RESET);
        rd(5'h18, 16'h0);
        rd(ADDR_IRQ_CLEAR, 16'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_wrap();
        wr(ADDR_PERIOD, 16'h5);
        wr(ADDR_IRQ_ENABLE, 16'h1);
        wr(ADDR_CONTROL, 16'h8000);
        wr(ADDR_COUNT, 16'h0);
        pul(8);
        rd(ADDR_COUNT, 16'h2);
        rd(ADDR_IRQ_STATUS, 16'h1);
        chk("irq", 16'h1, {15'h0, irq_o});
        wr(ADDR_IRQ_ENABLE, 16'h0);
        chk("irq", 16'h0, {15'h0, irq_o});
        wr(ADDR_IRQ_ENABLE, 16'h1);
        wr(ADDR_IRQ_CLEAR, 16'h1);
        rd(ADDR_IRQ_STATUS, 16'h0);
        chk("irq", 16'h0, {15'h0, irq_o});
        $display("t_wrap done");
    endtask : t_wrap
    task automatic t_scale();
        wr(ADDR_PERIOD, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, 16'h8000 | 16'(i << 4));
            wr(ADDR_COUNT, 16'h0);
            pul(2 * dv[i] + dv[i] / 2);
            rd(ADDR_COUNT, 16'h2);
        end
        wr(ADDR_CONTROL, 16'h0);
        rd(ADDR_COUNT, 16'h2);
        wr(ADDR_CONTROL, 16'h8030);
        pul(128);
        rd(ADDR_COUNT, 16'h2);
        $display("t_scale done");
    endtask : t_scale
    task automatic t_idle();
        wr(ADDR_CONTROL, 16'ha000);
        wr(ADDR_COUNT, 16'h0);
        idle <= 1'b1;
        pul(4);
        rd(ADDR_COUNT, 16'h0);
        wr(ADDR_CONTROL, 16'h8000);
        pul(4);
        rd(ADDR_COUNT, 16'h4);
        idle <= 1'b0;
        $display("t_idle done");
    endtask : t_idle
    task automatic t_sleep();
        slp <= 1'b1;
        wr(ADDR_COUNT, 16'h0);
        pul(4);
        rd(ADDR_COUNT, 16'h0);
        wr(ADDR_CONTROL, 16'h8002);
        wr(ADDR_PERIOD, 16'h1);
        edg(3);
        rd(ADDR_COUNT, 16'h1);
        wr(ADDR_PERIOD, 16'hffff);
        wr(ADDR_CONTROL, 16'h8006);
        edg(2);
        rd(ADDR_COUNT, 16'h1);
        slp <= 1'b0;
        repeat (4) @(posedge clk_i);
        edg(3);
        rd(ADDR_COUNT, 16'h4);
        wr(ADDR_CONTROL, 16'ha002);
        idle <= 1'b1;
        repeat (4) @(posedge clk_i);
        edg(2);
        rd(ADDR_COUNT, 16'h4);
        idle <= 1'b0;
        $display("t_sleep done");
    endtask : t_sleep
    task automatic t_gate();
        wr(ADDR_CONTROL, 16'h8040);
        wr(ADDR_IRQ_CLEAR, 16'h3);
        wr(ADDR_COUNT, 16'h0);
        pul(3);
        rd(ADDR_COUNT, 16'h0);
        pin <= 1'b1;
        pul(3);
        rd(ADDR_COUNT, 16'h3);
        pin <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(ADDR_IRQ_STATUS, 16'h2);
        $display("t_gate done");
    endtask : t_gate
    task automatic end_sim();
        $display("checked %0d bad %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        sel <= 4'h3;
        @(posedge clk_i);
        t_reset();
        t_wrap();
        t_scale();
        t_idle();
        t_sleep();
        t_gate();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end
endmodule : timer_one_counter_test
